// >>> logic/sba_guard_end.sv
// Arbiter and permission guard of the system bus.
// Assumes initiators hold requests until granted and that i_unlock_ok
// is a level from the system unlock logic.
// Operation
// - Least recently served order among normal initiators
// - Initiators carry numeric bus identities; CPU and DMA ones change with class
// - High class beats every normal initiator
// - Config bits pick DMA class, and CPU class while cpu_exl is set, for SRAM
// - Software keeps high class for light traffic
// - Fourteen targets with own region registers
// - Four permission groups; each initiator sits in one
// - Boot firmware assigns every initiator a group
// - Lock bit blocks permission and region writes
// - Lock bit changes only after unlock sequence
// - Base field is start address shifted ten
// - Size field means 2^(n-1) kilobytes
// - Read-only bases and sizes load at reset
// - Permission registers reset to groups 0-2
// - Target 11 maps serial memory and control
// - Single-region targets have no second descriptor
`timescale 1ns/1ps
`default_nettype none
module sba_guard_end
  import sba_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Control register port
  input wire logic i_cfg_we,
  input wire logic [6:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic i_unlock_ok,
  output logic [31:0] o_cfg_rdata,
  // Violation record and lock bit
  input wire logic i_viol_clr,
  output logic o_viol_flag,
  output logic [3:0] o_viol_id,
  output logic [4:0] o_viol_rgn,
  output logic o_lock,
  // Bus
  sba_if.dev bus
);
  logic dma_sram_priority_select_r, dma_sram_priority_select_nxt, cpu_sram_priority_select_r, cpu_sram_priority_select_nxt, lock_r, lock_nxt;
  logic [1:0] grp_r [11];
  logic [1:0] grp_nxt [11];
  sba_base_t base_r [14][2];
  sba_base_t base_nxt [14][2];
  sba_size_t size_r [14][2];
  sba_size_t size_nxt [14][2];
  sba_perm_t rdp_r [14][2];
  sba_perm_t rdp_nxt [14][2];
  sba_perm_t wrp_r [14][2];
  sba_perm_t wrp_nxt [14][2];
  logic [10:0] older_r [11];
  logic [10:0] older_nxt [11];
  logic [10:0] gnt_r, gnt_nxt;
  logic err_r, err_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic viol_r, viol_nxt;
  logic [3:0] vid_r, vid_nxt;
  logic [4:0] vrgn_r, vrgn_nxt;
  logic [1:0] kind;
  logic [3:0] tsel;
  logic rsel;
  logic [10:0] hi, cand, pool, win;
  int unsigned w;
  sba_base_t akb;
  sba_base_t akb_w;
  logic [4:0] rgn;
  logic hit_any, allow;

  assign kind = i_cfg_addr[6:5];
  assign tsel = i_cfg_addr[4:1];
  assign rsel = i_cfg_addr[0];

  // Class and winner selection
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      akb = bus.addr[i][31:`SBA_KB_SHIFT];
      hi[i] = 1'b0;
      if (i == 9) hi[i] = 1'b1;
      if (akb >= `SBA_SRAM_LO_KB && akb < `SBA_SRAM_HI_KB) begin
        if (i == 0) hi[i] = cpu_sram_priority_select_r && bus.cpu_exl;
        if (i == 1 || i == 2) hi[i] = dma_sram_priority_select_r;
      end
    end
    // The lane granted last cycle may still show its request
    cand = bus.req & ~gnt_r;
    pool = (|(cand & hi)) ? (cand & hi) : cand;
    w = 0;
    for (int i = 0; i < 11; i++) begin
      win[i] = pool[i];
      for (int j = 0; j < 11; j++) begin
        if (j != i && pool[j] && !older_r[i][j]) win[i] = 1'b0;
      end
      if (win[i]) w = i;
    end
  end

  // Region lookup and permission check of the winner
  always_comb begin
    // Own copy of the winner's address; the class logic drives akb
    akb_w = bus.addr[w][31:`SBA_KB_SHIFT];
    rgn = `SBA_NO_RGN;
    hit_any = 1'b0;
    allow = 1'b0;
    for (int t = 0; t < 14; t++) begin
      for (int r = 0; r < 2; r++) begin
        // Second region wins an overlap with the first, being the higher priority level; a higher target wins over a lower one
        if (sba_hit(akb_w, base_r[t][r], size_r[t][r])) begin
          hit_any = 1'b1;
          rgn = 5'({t[3:0], r[0]});
          allow = bus.wr[w] ? wrp_r[t][r][grp_r[w]] : rdp_r[t][r][grp_r[w]];
        end
      end
    end
  end

  // Grant, response and violation record
  always_comb begin
    gnt_nxt = |pool ? win : 11'h000;
    err_nxt = |pool && !(hit_any && allow);
    older_nxt = older_r;
    if (|pool) begin
      for (int j = 0; j < 11; j++) begin
        older_nxt[w][j] = 1'b0;
        older_nxt[j][w] = (j != w);
      end
    end
    viol_nxt = viol_r && !i_viol_clr;
    vid_nxt = vid_r;
    vrgn_nxt = vrgn_r;
    // A new violation wins over a clear in the same cycle
    if (err_nxt) begin
      viol_nxt = 1'b1;
      vid_nxt = sba_id(w, hi[w]);
      vrgn_nxt = rgn;
    end
  end

  // Control register writes and read-back
  always_comb begin
    dma_sram_priority_select_nxt = dma_sram_priority_select_r;
    cpu_sram_priority_select_nxt = cpu_sram_priority_select_r;
    lock_nxt = lock_r;
    grp_nxt = grp_r;
    base_nxt = base_r;
    size_nxt = size_r;
    rdp_nxt = rdp_r;
    wrp_nxt = wrp_r;
    rdata_nxt = 32'h00000000;
    if (i_cfg_we && kind == `SBA_K_MISC && i_cfg_addr[4:0] == 5'(`SBA_M_CFG)) begin
      dma_sram_priority_select_nxt = i_cfg_wdata[`SBA_B_DMA_SRAM_PRIORITY_SELECT];
      cpu_sram_priority_select_nxt = i_cfg_wdata[`SBA_B_CPU_SRAM_PRIORITY_SELECT];
      if (i_unlock_ok) lock_nxt = i_cfg_wdata[`SBA_B_LOCK];
    end
    if (i_cfg_we && !lock_r && tsel < 4'he) begin
      unique case (kind)
        `SBA_K_MISC: begin
          if (i_cfg_addr[4:0] == 5'(`SBA_M_GRP)) begin
            for (int i = 0; i < 11; i++) grp_nxt[i] = i_cfg_wdata[2*i +: 2];
          end
        end
        `SBA_K_DESC: begin
          if (sba_desc_rw(tsel, rsel)) begin
            base_nxt[tsel][rsel] = i_cfg_wdata[31:`SBA_D_BASE_LSB];
            size_nxt[tsel][rsel] = i_cfg_wdata[`SBA_D_SIZE_LSB +: 5];
          end
        end
        `SBA_K_RD: if (rsel == 1'b0 || sba_has_r1(tsel)) rdp_nxt[tsel][rsel] = i_cfg_wdata[3:0];
        `SBA_K_WR: if (rsel == 1'b0 || sba_has_r1(tsel)) wrp_nxt[tsel][rsel] = i_cfg_wdata[3:0];
      endcase
    end
    // Reads of absent descriptors return zero
    if (tsel < 4'he && (rsel == 1'b0 || sba_has_r1(tsel))) begin
      unique case (kind)
        `SBA_K_MISC: begin
          if (i_cfg_addr[4:0] == 5'(`SBA_M_CFG)) begin
            rdata_nxt[`SBA_B_DMA_SRAM_PRIORITY_SELECT] = dma_sram_priority_select_r;
            rdata_nxt[`SBA_B_CPU_SRAM_PRIORITY_SELECT] = cpu_sram_priority_select_r;
            rdata_nxt[`SBA_B_LOCK] = lock_r;
          end else if (i_cfg_addr[4:0] == 5'(`SBA_M_GRP)) begin
            for (int i = 0; i < 11; i++) rdata_nxt[2*i +: 2] = grp_r[i];
          end else if (i_cfg_addr[4:0] == 5'(`SBA_M_VIOL)) begin
            rdata_nxt[9:0] = {viol_r, vid_r, vrgn_r};
          end
        end
        `SBA_K_DESC: begin
          rdata_nxt[31:`SBA_D_BASE_LSB] = base_r[tsel][rsel];
          rdata_nxt[`SBA_D_SIZE_LSB +: 5] = size_r[tsel][rsel];
          rdata_nxt[`SBA_D_PRI_BIT] = rsel;
        end
        `SBA_K_RD: rdata_nxt[3:0] = rdp_r[tsel][rsel];
        `SBA_K_WR: rdata_nxt[3:0] = wrp_r[tsel][rsel];
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dma_sram_priority_select_r <= 1'b0;
      cpu_sram_priority_select_r <= 1'b0;
      lock_r <= 1'b0;
      gnt_r <= 11'h000;
      err_r <= 1'b0;
      rdata_r <= 32'h00000000;
      viol_r <= 1'b0;
      vid_r <= 4'h0;
      vrgn_r <= 5'h00;
      for (int i = 0; i < 11; i++) begin
        grp_r[i] <= 2'h0;
        for (int j = 0; j < 11; j++) older_r[i][j] <= (i < j);
      end
      for (int t = 0; t < 14; t++) begin
        for (int r = 0; r < 2; r++) begin
          base_r[t][r] <= sba_rst_base(t, r[0]);
          size_r[t][r] <= sba_rst_size(t, r[0]);
          rdp_r[t][r] <= (r == 0 || sba_has_r1(t)) ? `SBA_PERM_RST : 4'h0;
          wrp_r[t][r] <= (r == 0 || sba_has_r1(t)) ? `SBA_PERM_RST : 4'h0;
        end
      end
    end else begin
      dma_sram_priority_select_r <= dma_sram_priority_select_nxt;
      cpu_sram_priority_select_r <= cpu_sram_priority_select_nxt;
      lock_r <= lock_nxt;
      grp_r <= grp_nxt;
      base_r <= base_nxt;
      size_r <= size_nxt;
      rdp_r <= rdp_nxt;
      wrp_r <= wrp_nxt;
      older_r <= older_nxt;
      gnt_r <= gnt_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
      viol_r <= viol_nxt;
      vid_r <= vid_nxt;
      vrgn_r <= vrgn_nxt;
    end
  end

  assign bus.gnt = gnt_r;
  assign bus.err = err_r;
  assign o_cfg_rdata = rdata_r;
  assign o_viol_flag = viol_r;
  assign o_viol_id = vid_r;
  assign o_viol_rgn = vrgn_r;
  assign o_lock = lock_r;
endmodule : sba_guard_end
`default_nettype wire

// >>> logic/sba_map.svh
// Constants for the system bus arbiter and permission guard.
// Assumes the includer supplies the types; this file only holds macros.
`ifndef SBA_MAP_SVH
`define SBA_MAP_SVH
`define SBA_N_INIT 11
`define SBA_N_TGT 14
`define SBA_B_DMA_SRAM_PRIORITY_SELECT 25
`define SBA_B_CPU_SRAM_PRIORITY_SELECT 24
`define SBA_B_LOCK 11
`define SBA_PERM_RST 4'h7
`define SBA_KB_SHIFT 10
`define SBA_SRAM_LO_KB 22'h000000
`define SBA_SRAM_HI_KB 22'h000200
`define SBA_K_MISC 2'h0
`define SBA_K_DESC 2'h1
`define SBA_K_RD 2'h2
`define SBA_K_WR 2'h3
`define SBA_M_CFG 4'h0
`define SBA_M_GRP 4'h1
`define SBA_M_VIOL 4'h2
`define SBA_D_BASE_LSB 10
`define SBA_D_SIZE_LSB 4
`define SBA_D_PRI_BIT 3
`define SBA_NO_RGN 5'h1f
`define SBA_T6_BASE 22'h07e080
`define SBA_T7_BASE 22'h07e100
`define SBA_T8_BASE 22'h07e180
`define SBA_T9_BASE 22'h07e200
`define SBA_T10_BASE 22'h07e38c
`define SBA_T11_BASE 22'h0c0000
`define SBA_T11R1_BASE 22'h07e388
`define SBA_T12_BASE 22'h07e394
`define SBA_T13_BASE 22'h07e398
`define SBA_SZ_64K 5'h07
`define SBA_SZ_4K 5'h03
`define SBA_SZ_64M 5'h11
`endif

// >>> logic/sba_pkg.sv
// Types and lookup functions for the system bus arbiter and permission guard.
// Assumes sba_map.svh is on the include path.
`default_nettype none
`include "sba_map.svh"
package sba_pkg;
  typedef enum logic [3:0] {
    SBA_CPU, SBA_DMA_RD, SBA_DMA_WR, SBA_USB, SBA_ETH_RD, SBA_ETH_WR,
    SBA_CAN1, SBA_CAN2, SBA_QSI, SBA_FLASH, SBA_CRYPTO
  } sba_init_t;
  typedef logic [21:0] sba_base_t;
  typedef logic [4:0] sba_size_t;
  typedef logic [3:0] sba_perm_t;

  // Fixed start of a region (in KB) loaded at reset
  function automatic sba_base_t sba_rst_base(input int unsigned t, input bit r);
    case (t)
      6: sba_rst_base = `SBA_T6_BASE;
      7: sba_rst_base = `SBA_T7_BASE;
      8: sba_rst_base = `SBA_T8_BASE;
      9: sba_rst_base = `SBA_T9_BASE;
      10: sba_rst_base = `SBA_T10_BASE;
      11: sba_rst_base = r ? `SBA_T11R1_BASE : `SBA_T11_BASE;
      12: sba_rst_base = `SBA_T12_BASE;
      13: sba_rst_base = `SBA_T13_BASE;
      default: sba_rst_base = 22'h000000;
    endcase
    if (r && t != 11) sba_rst_base = 22'h000000;
  endfunction : sba_rst_base

  // Fixed size code of a region loaded at reset; zero means empty
  function automatic sba_size_t sba_rst_size(input int unsigned t, input bit r);
    if (r) sba_rst_size = (t == 11) ? `SBA_SZ_4K : 5'h00;
    else if (t >= 6 && t <= 9) sba_rst_size = `SBA_SZ_64K;
    else if (t == 11) sba_rst_size = `SBA_SZ_64M;
    else if (t >= 10) sba_rst_size = `SBA_SZ_4K;
    else sba_rst_size = 5'h00;
  endfunction : sba_rst_size

  // Targets with a second region descriptor
  function automatic bit sba_has_r1(input int unsigned t);
    sba_has_r1 = !(t == 10 || t == 12 || t == 13);
  endfunction : sba_has_r1

  // Base and size fields that software may write
  function automatic bit sba_desc_rw(input int unsigned t, input bit r);
    sba_desc_rw = r && sba_has_r1(t) && t != 11;
  endfunction : sba_desc_rw

  // Length is 2^(size-1) KB; size 0 matches nothing
  function automatic bit sba_hit(input sba_base_t a, input sba_base_t b, input sba_size_t s);
    logic [31:0] span;
    logic [31:0] off;
    span = 32'h1 << (s - 5'h01);
    off = {10'h000, a} - {10'h000, b};
    sba_hit = (s != 5'h00) && (a >= b) && (off < span);
  endfunction : sba_hit

  // Bus identity of an initiator port, normal or high class
  function automatic logic [3:0] sba_id(input int unsigned i, input bit hi);
    case (i)
      0: sba_id = hi ? 4'h2 : 4'h1;
      1: sba_id = hi ? 4'h4 : 4'h3;
      2: sba_id = hi ? 4'h6 : 4'h5;
      default: sba_id = 4'(i + 4);
    endcase
  endfunction : sba_id
endpackage : sba_pkg
`default_nettype wire

// >>> logic/sba_if.sv
// Request and grant wires between the bus initiators and the arbiter.
// Assumes both ends share one clock; each initiator owns one lane.
`timescale 1ns/1ps
`default_nettype none
interface sba_if;
  logic [10:0] req;
  logic [10:0] wr;
  logic [31:0] addr [11];
  logic cpu_exl;
  logic [10:0] gnt;
  logic err;
  modport dev (input req, wr, addr, cpu_exl, output gnt, err);
  modport init (output req, wr, addr, cpu_exl, input gnt, err);
endinterface : sba_if
`default_nettype wire

// >>> logic/sba_init_end.sv
// Initiator side: holds each port's request on the bus until it is granted.
// Assumes the arbiter answers a held request with a one-cycle grant.
`timescale 1ns/1ps
`default_nettype none
module sba_init_end
  import sba_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // User commands, one lane per initiator
  input wire logic [10:0] i_cmd_valid,
  input wire logic [10:0] i_cmd_wr,
  input wire logic [31:0] i_cmd_addr [11],
  input wire logic i_cpu_exl,
  output logic [10:0] o_cmd_ready,
  output logic [10:0] o_done,
  output logic [10:0] o_err,
  // Bus
  sba_if.init bus
);
  logic [10:0] busy_r, busy_nxt, wr_r, wr_nxt, done_r, done_nxt, err_r, err_nxt;
  logic [31:0] addr_r [11];
  logic [31:0] addr_nxt [11];
  logic exl_r, exl_nxt;

  // Take a command when idle, release on grant
  always_comb begin
    busy_nxt = busy_r;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    exl_nxt = i_cpu_exl;
    done_nxt = bus.gnt;
    err_nxt = bus.gnt & {11{bus.err}};
    for (int i = 0; i < 11; i++) begin
      if (bus.gnt[i]) begin
        busy_nxt[i] = 1'b0;
      end else if (!busy_r[i] && i_cmd_valid[i]) begin
        busy_nxt[i] = 1'b1;
        wr_nxt[i] = i_cmd_wr[i];
        addr_nxt[i] = i_cmd_addr[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_r <= 11'h000;
      wr_r <= 11'h000;
      done_r <= 11'h000;
      err_r <= 11'h000;
      exl_r <= 1'b0;
      for (int i = 0; i < 11; i++) addr_r[i] <= 32'h00000000;
    end else begin
      busy_r <= busy_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      exl_r <= exl_nxt;
      addr_r <= addr_nxt;
    end
  end

  // The lane becomes ready again, with o_done, the cycle after its grant
  assign bus.req = busy_r;
  assign bus.wr = wr_r;
  assign bus.addr = addr_r;
  assign bus.cpu_exl = exl_r;
  assign o_cmd_ready = ~busy_r;
  assign o_done = done_r;
  assign o_err = err_r;
endmodule : sba_init_end
`default_nettype wire

// >>> dv/sba_asserts.sv
// Checker on the request and grant wires between the two ends.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sba_asserts (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Bus wires
  input wire logic [10:0] req,
  input wire logic [10:0] gnt,
  input wire logic err
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic [10:0] pend_r;
  logic [10:0] pend_nxt;
  // Lanes left waiting at an edge must still ask at the next
  always_comb pend_nxt = req & ~gnt;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) pend_r <= 11'h000;
    else pend_r <= pend_nxt;
  end
  // One lane asks while the bus is idle
  sequence s_lone;
    $onehot(req) && (gnt == 11'h000);
  endsequence
  // Flash waits and no CPU or DMA lane can claim high class
  sequence s_flash_wait;
    req[9] && !gnt[9] && (req[2:0] == 3'h0);
  endsequence
  property p_onehot;
    $onehot0(gnt);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one lane granted");
  property p_need_req;
    (gnt & ~$past(req)) == 11'h000;
  endproperty
  a_need_req: assert property (p_need_req)
    else $error("grant without a request");
  property p_no_regrant;
    (gnt & $past(gnt)) == 11'h000;
  endproperty
  a_no_regrant: assert property (p_no_regrant)
    else $error("lane granted twice in a row");
  property p_err_gnt;
    err |-> (gnt != 11'h000);
  endproperty
  a_err_gnt: assert property (p_err_gnt)
    else $error("error without a grant");
  property p_flash;
    s_flash_wait |=> gnt[9];
  endproperty
  a_flash: assert property (p_flash)
    else $error("flash lane lost to a normal lane");
  property p_single;
    s_lone |=> (gnt == $past(req));
  endproperty
  a_single: assert property (p_single)
    else $error("lone request not served next cycle");
  property p_hold;
    (pend_r & ~req) == 11'h000;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped before grant");
  property p_drop;
    (req & $past(gnt)) == 11'h000;
  endproperty
  a_drop: assert property (p_drop)
    else $error("request kept after grant");
endmodule : sba_asserts
`default_nettype wire

// >>> dv/test_system_bus_arbiter_permission.sv
// Bench for the bus arbiter and permission guard, both ends joined by sba_if.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_system_bus_arbiter_permission;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [10:0] cmd_valid = 11'h000;
  logic [10:0] cmd_wr = 11'h000;
  logic [31:0] cmd_addr [11];
  logic cpu_exl = 1'b0;
  logic cfg_we = 1'b0;
  logic [6:0] cfg_addr = 7'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic unlock_ok = 1'b0;
  logic viol_clr = 1'b0;
  wire logic [10:0] done;
  wire logic [10:0] ready;
  wire logic [10:0] berr;
  wire logic [31:0] rdata;
  wire logic vflag;
  wire logic [3:0] vid;
  wire logic [4:0] vrgn;
  wire logic lock;
  int fail_count = 0;
  int checks_done = 0;
  sba_if bus ();
  sba_init_end i_sba_init_end (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_cmd_valid(cmd_valid), .i_cmd_wr(cmd_wr), .i_cmd_addr(cmd_addr), .i_cpu_exl(cpu_exl),
    .o_cmd_ready(ready), .o_done(done), .o_err(berr), .bus(bus.init));
  sba_guard_end i_sba_guard_end (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_cfg_we(cfg_we), .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata), .i_unlock_ok(unlock_ok),
    .o_cfg_rdata(rdata), .i_viol_clr(viol_clr), .o_viol_flag(vflag), .o_viol_id(vid),
    .o_viol_rgn(vrgn), .o_lock(lock), .bus(bus.dev));
  sba_asserts i_sba_asserts (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .req(bus.req), .gnt(bus.gnt), .err(bus.err));
  // Free-running 100 MHz clock
  always #5 i_ref_clk = ~i_ref_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A hung transfer ends the run rather than stalling it
  task automatic stall;
    fail_count++;
    $display("ERROR %0t transfer never completed", $time);
    print_verdict();
  endtask : stall
  // Inputs move one step after the edge so sampling never races
  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask : tick
  function automatic logic [6:0] ad(input int k, input int t, input int r);
    ad = 7'((k << 5) | (t << 1) | r);
  endfunction : ad
  // Descriptor image: base in KB above bit 10, size code, level bit
  function automatic logic [31:0] desc(input logic [31:0] phys, input int kb, input int hi);
    desc = (phys & 32'hfffffc00) | 32'(($clog2(kb) + 1) << 4) | 32'(hi << 3);
  endfunction : desc
  task automatic cfg_wr(input logic [6:0] a, input logic [31:0] d);
    tick();
    cfg_addr = a;
    cfg_wdata = d;
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
  endtask : cfg_wr
  // Read data is registered one cycle after the address
  task automatic cfg_rd(input logic [6:0] a, input logic [31:0] exp);
    tick();
    cfg_addr = a;
    tick();
    chk(rdata, exp);
  endtask : cfg_rd
  task automatic bus_op(input int ln, input logic w, input logic [31:0] a, input logic e);
    int n;
    tick();
    cmd_addr[ln] = a;
    cmd_wr[ln] = w;
    cmd_valid[ln] = 1'b1;
    tick();
    cmd_valid[ln] = 1'b0;
    chk({31'h0, ready[ln]}, 32'h0);
    for (n = 0; n < 40 && done[ln] !== 1'b1; n++) tick();
    if (done[ln] !== 1'b1) stall();
    chk({31'h0, ready[ln]}, 32'h1);
    chk({31'h0, berr[ln]}, {31'h0, e});
  endtask : bus_op
  // Launch several lanes together and check which finishes first
  task automatic race(input logic [10:0] m, input int first);
    logic [10:0] got;
    int n;
    got = 11'h000;
    tick();
    cmd_valid = m;
    tick();
    cmd_valid = 11'h000;
    for (n = 0; n < 60 && got != m; n++) begin
      if (got == 11'h000 && done != 11'h000) chk({21'h0, done}, 32'h1 << first);
      got = got | done;
      tick();
    end
    if (got != m) stall();
  endtask : race
  initial begin
    for (int i = 0; i < 11; i++) cmd_addr[i] = (i < 2) ? 32'h00000100 : 32'h1f820000;
    repeat (20) @(posedge i_ref_clk);
    #1 i_sys_rst = 1'b0;
    cfg_rd(ad(0, 0, 0), 32'h0);
    cfg_rd(ad(0, 0, 1), 32'h0);
    for (int t = 6; t < 10; t++) begin
      cfg_rd(ad(1, t, 0), desc(32'h1f820000 + 32'(t - 6) * 32'h20000, 64, 0));
    end
    cfg_rd(ad(1, 10, 0), desc(32'h1f8e3000, 4, 0));
    cfg_rd(ad(1, 11, 0), desc(32'h30000000, 65536, 0));
    cfg_rd(ad(1, 11, 1), desc(32'h1f8e2000, 4, 1));
    cfg_rd(ad(1, 13, 0), desc(32'h1f8e6000, 4, 0));
    cfg_rd(ad(1, 6, 1), 32'h8);
    cfg_rd(ad(1, 10, 1), 32'h0);
    cfg_rd(ad(2, 12, 1), 32'h0);
    cfg_rd(ad(1, 14, 0), 32'h0);
    for (int t = 0; t < 14; t++) begin
      cfg_rd(ad(2, t, 0), 32'h7);
      cfg_rd(ad(3, t, 0), 32'h7);
    end
    $display("test reset values done");
    bus_op(3, 1'b0, 32'h1f820004, 1'b0);
    cfg_wr(ad(0, 0, 1), 32'hc0);
    bus_op(3, 1'b0, 32'h1f820004, 1'b1);
    chk({22'h0, vflag, vid, vrgn}, 32'h2ec);
    cfg_rd(ad(0, 0, 2), 32'h2ec);
    cfg_wr(ad(3, 6, 0), 32'h8);
    bus_op(3, 1'b1, 32'h1f820008, 1'b0);
    tick();
    viol_clr = 1'b1;
    tick();
    viol_clr = 1'b0;
    chk({31'h0, vflag}, 32'h0);
    bus_op(4, 1'b0, 32'h00040010, 1'b1);
    chk({23'h0, vid, vrgn}, 32'h11f);
    $display("test permissions done");
    cfg_wr(ad(0, 0, 0), 32'h800);
    chk({31'h0, lock}, 32'h0);
    unlock_ok = 1'b1;
    cfg_wr(ad(0, 0, 0), 32'h800);
    unlock_ok = 1'b0;
    chk({31'h0, lock}, 32'h1);
    cfg_wr(ad(2, 6, 1), 32'h3);
    cfg_rd(ad(2, 6, 1), 32'h7);
    cfg_wr(ad(0, 0, 1), 32'h0);
    cfg_rd(ad(0, 0, 1), 32'hc0);
    cfg_wr(ad(0, 0, 0), 32'h2000000);
    cfg_rd(ad(0, 0, 0), 32'h2000800);
    unlock_ok = 1'b1;
    cfg_wr(ad(0, 0, 0), 32'h0);
    unlock_ok = 1'b0;
    chk({31'h0, lock}, 32'h0);
    cfg_wr(ad(2, 6, 1), 32'h3);
    cfg_rd(ad(2, 6, 1), 32'h3);
    cfg_wr(ad(1, 6, 0), 32'h0);
    cfg_rd(ad(1, 6, 0), desc(32'h1f820000, 64, 0));
    cfg_wr(ad(1, 6, 1), 32'h00040070);
    cfg_rd(ad(1, 6, 1), 32'h00040078);
    bus_op(4, 1'b0, 32'h0004fffc, 1'b0);
    bus_op(4, 1'b0, 32'h00050000, 1'b1);
    $display("test lock and regions done");
    bus_op(6, 1'b0, 32'h1f820000, 1'b0);
    race(11'h0c0, 7);
    race(11'h2c0, 9);
    bus_op(1, 1'b0, 32'h00000100, 1'b1);
    race(11'h042, 6);
    cfg_wr(ad(0, 0, 0), 32'h2000000);
    race(11'h042, 1);
    chk({23'h0, vid, vrgn}, 32'h09f);
    cfg_wr(ad(0, 0, 0), 32'h1000000);
    bus_op(0, 1'b0, 32'h00000100, 1'b1);
    chk({23'h0, vid, vrgn}, 32'h03f);
    race(11'h041, 6);
    cpu_exl = 1'b1;
    race(11'h041, 0);
    chk({23'h0, vid, vrgn}, 32'h05f);
    $display("test arbitration done");
    print_verdict();
  end
endmodule : test_system_bus_arbiter_permission
`default_nettype wire
